// File: core/rscr_pkg.sv
// package for the redundancy command and status register bank
// assumes one 40 MHz clock and a peer unit on the same clock
package rscr_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int W = 16;
  localparam int ADDR_W = 10;
  localparam int MEM_WORDS = 128;
  localparam int MIDX_W = 7;
  localparam int BACK_WORDS = 4;
  localparam logic [MIDX_W-1:0] NONXFER_WORDS = 7'h64;
  localparam logic [MIDX_W-1:0] MEM_LAST = 7'h7f;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CMD = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 10'h004;
  localparam logic [5:0] ADDR_BACK_PAGE = 6'h01;

  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int CMD_RUN_A = 1;
  localparam int CMD_RUN_B = 2;
  localparam int CMD_FW_TOL = 4;
  localparam logic [W-1:0] CMD_USED = 16'h0016;
  localparam logic [W-1:0] CMD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // state word fields
  // ----------------------------------------------------------------
  localparam int ST_LOGIC_MM = 4;
  localparam int ST_UNIT_B = 5;
  localparam int ST_LINK_BAD = 6;
  localparam int ST_CPU_MM = 7;
  localparam int ST_COPRO_MM = 8;
  localparam int ST_ETY_OLD = 9;
  localparam int ST_ETY_MM = 10;
  localparam int ST_ADDR_PLUS = 13;
  localparam int ST_COPRO_OK = 15;

  // role codes, high bit first
  localparam logic [1:0] ROLE_NONE = 2'h0;
  localparam logic [1:0] ROLE_OFFLINE = 2'h1;
  localparam logic [1:0] ROLE_PRIMARY = 2'h2;
  localparam logic [1:0] ROLE_STANDBY = 2'h3;

  typedef enum logic [1:0] {
    RS_OFFLINE,
    RS_PRIMARY,
    RS_STANDBY
  } rscr_role_t;

  // one frame of the peer synchronisation link
  typedef struct packed {
    logic alive;
    logic [1:0] role;
    logic [W-1:0] cmd;
    logic [BACK_WORDS*W-1:0] back;
    logic [W-1:0] logic_sig;
    logic [W-1:0] cpu_fw;
    logic [W-1:0] copro_fw;
    logic [W-1:0] ety_fw;
    logic [47:0] mac;
    logic mem_valid;
    logic [MIDX_W-1:0] mem_idx;
    logic [W-1:0] mem_data;
  } rscr_link_t;

endpackage

// File: core/rscr_regs.sv
// command, state, reverse words and memory of one redundant unit
// assumes the peer link and the scan tick are logic on MCLK
//
// Function
// RULE1 - bit 1 requests run or offline, unit A
// RULE2 - bit 2 requests run or offline, unit B
// RULE3 - primary command word overwrites standby every scan
// RULE4 - bit 4 tolerates firmware mismatch in standby
// RULE5 - only standby compares firmware versions
// RULE6 - local state word, never copied from peer
// RULE7 - bits 1:0 local role code
// RULE8 - bits 3:2 remote role, zero if unreachable
// RULE9 - bit 4 flags program or configuration mismatch
// RULE10 - bit 5 zero on lower address unit
// RULE11 - bit 6 flags bad link, bit 5 moot
// RULE12 - bit 7 processor firmware mismatch stops redundancy
// RULE13 - bit 8 coprocessor firmware mismatch stops redundancy
// RULE14 - bit 9 old network firmware forces offline
// RULE15 - bit 10 network firmware mismatch stops redundancy
// RULE16 - bit 13 shows address plus one in use
// RULE17 - bit 15 coprocessor good, else bit 6 set
// RULE18 - four reverse words standby to primary
// RULE19 - words 0 to 99 never transferred
// RULE20 - sixteen bit words, unused bits zero
// RULE21 - standby runs first section, offline nothing
`timescale 1ns/1ps
`default_nettype none

module rscr_regs
  import rscr_pkg::*;
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output var logic [W-1:0] RDATA,
  input wire logic SCAN_TICK,
  input wire logic [47:0] LOCAL_MAC,
  input wire logic [W-1:0] LOCAL_CPU_FW,
  input wire logic [W-1:0] LOCAL_COPRO_FW,
  input wire logic [W-1:0] LOCAL_ETY_FW,
  input wire logic [W-1:0] LOCAL_LOGIC_SIG,
  input wire logic ETY_MIN_OK,
  input wire logic COPRO_OK,
  input wire rscr_link_t LINK_RX,
  output var rscr_link_t LINK_TX,
  output var logic RUN_FIRST_SECTION,
  output var logic RUN_ALL_SECTIONS,
  output var logic IO_ENABLE,
  output var logic ADDR_PLUS_ONE
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] role_code(input rscr_role_t r);
    case (r)
      RS_PRIMARY: role_code = ROLE_PRIMARY;
      RS_STANDBY: role_code = ROLE_STANDBY;
      default: role_code = ROLE_OFFLINE;
    endcase
  endfunction

  function automatic logic differs(
    input logic [W-1:0] a,
    input logic [W-1:0] b
  );
    differs = a != b;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rscr_role_t role;
  rscr_role_t next_role;
  logic [W-1:0] cmd;
  logic [W-1:0] back [BACK_WORDS];
  logic [W-1:0] mem [MEM_WORDS];
  logic [1:0] peer_code;
  logic logic_mm;
  logic unit_b;
  logic link_bad;
  logic cpu_mm;
  logic copro_mm;
  logic ety_mm;
  logic ety_old;
  logic sweep_on;
  logic [MIDX_W-1:0] sweep_idx;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire word_ok = ADDR[1:0] == 2'h0;
  wire sel_cmd = ADDR == ADDR_CMD;
  wire sel_state = ADDR == ADDR_STATE;
  wire sel_back = word_ok && ADDR[9:4] == ADDR_BACK_PAGE;
  wire sel_mem = word_ok && ADDR[9];
  wire [1:0] back_idx = ADDR[3:2];
  wire [MIDX_W-1:0] mem_idx = ADDR[8:2];
  wire wr_cmd = WR && sel_cmd;
  wire wr_back = WR && sel_back;
  wire wr_mem = WR && sel_mem;

  // ----------------------------------------------------------------
  // peer comparison
  // ----------------------------------------------------------------
  wire link_ok = LINK_RX.alive && COPRO_OK; // RULE17
  wire peer_primary = link_ok && LINK_RX.role == ROLE_PRIMARY;
  wire peer_standby = link_ok && LINK_RX.role == ROLE_STANDBY;
  wire cmp_logic = differs(LOCAL_LOGIC_SIG, LINK_RX.logic_sig);
  wire cmp_cpu = differs(LOCAL_CPU_FW, LINK_RX.cpu_fw);
  wire cmp_copro = differs(LOCAL_COPRO_FW, LINK_RX.copro_fw);
  wire cmp_ety = differs(LOCAL_ETY_FW, LINK_RX.ety_fw);
  wire cmp_fw = cmp_cpu || cmp_copro || cmp_ety;
  // mismatch tolerated only while the command bit is set
  wire fw_block = cmp_fw && !cmd[CMD_FW_TOL]; // RULE4
  wire standby_unfit = cmp_logic || fw_block || !link_ok;
  wire id_b = LOCAL_MAC > LINK_RX.mac;

  // ----------------------------------------------------------------
  // role selection
  // ----------------------------------------------------------------
  wire run_a = cmd[CMD_RUN_A]; // RULE1
  wire run_b = cmd[CMD_RUN_B]; // RULE2
  wire run_req = unit_b ? run_b : run_a;

  always_comb begin
    next_role = role;
    if (!run_req || !ETY_MIN_OK) begin // RULE14
      next_role = RS_OFFLINE;
    end else begin
      case (role)
        RS_OFFLINE: begin
          if (peer_primary) begin
            // mismatch stops redundant operation
            next_role = standby_unfit ? RS_OFFLINE : RS_STANDBY; // RULE12
          end else if (!peer_standby) begin
            next_role = RS_PRIMARY;
          end
        end
        RS_PRIMARY: begin
          // two primaries: the higher address unit yields
          if (peer_primary && unit_b) begin
            next_role = standby_unfit ? RS_OFFLINE : RS_STANDBY;
          end
        end
        RS_STANDBY: begin
          if (!peer_primary) begin
            next_role = RS_PRIMARY;
          end else if (standby_unfit) begin
            next_role = RS_OFFLINE; // RULE13 RULE15
          end
        end
        default: begin
          next_role = RS_OFFLINE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      role <= RS_OFFLINE;
    end else if (SCAN_TICK) begin
      role <= next_role;
    end
  end

  // ----------------------------------------------------------------
  // program section enables
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      RUN_FIRST_SECTION <= 1'b0;
      RUN_ALL_SECTIONS <= 1'b0;
      IO_ENABLE <= 1'b0;
      ADDR_PLUS_ONE <= 1'b0;
    end else begin
      RUN_FIRST_SECTION <= role != RS_OFFLINE; // RULE21
      RUN_ALL_SECTIONS <= role == RS_PRIMARY; // RULE21
      IO_ENABLE <= role != RS_OFFLINE; // RULE21
      ADDR_PLUS_ONE <= role == RS_STANDBY; // RULE16
    end
  end

  // ----------------------------------------------------------------
  // command word
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      cmd <= CMD_RESET;
    end else if (SCAN_TICK && role == RS_STANDBY && peer_primary) begin
      // peer copy wins over a local write
      cmd <= LINK_RX.cmd & CMD_USED; // RULE3
    end else if (wr_cmd) begin
      cmd <= WDATA & CMD_USED; // RULE20
    end
  end

  // ----------------------------------------------------------------
  // reverse words
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < BACK_WORDS; i++) begin
        back[i] <= 16'h0000;
      end
    end else if (SCAN_TICK && role == RS_PRIMARY && peer_standby) begin
      for (int i = 0; i < BACK_WORDS; i++) begin
        back[i] <= LINK_RX.back[i*W +: W]; // RULE18
      end
    end else if (wr_back) begin
      back[back_idx] <= WDATA;
    end
  end

  // ----------------------------------------------------------------
  // state word sources
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      peer_code <= ROLE_NONE;
      link_bad <= 1'b1;
      unit_b <= 1'b0;
      logic_mm <= 1'b0;
      ety_old <= 1'b0;
    end else begin
      link_bad <= !link_ok; // RULE11 RULE17
      ety_old <= !ETY_MIN_OK; // RULE14
      if (SCAN_TICK) begin
        peer_code <= link_ok ? LINK_RX.role : ROLE_NONE; // RULE8
        logic_mm <= link_ok && cmp_logic; // RULE9
        if (link_ok) begin
          unit_b <= id_b; // RULE10
        end
      end
    end
  end

  // firmware checks run on the standby side only
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      cpu_mm <= 1'b0;
      copro_mm <= 1'b0;
      ety_mm <= 1'b0;
    end else if (SCAN_TICK && role == RS_STANDBY) begin // RULE5
      cpu_mm <= link_ok && cmp_cpu; // RULE12
      copro_mm <= link_ok && cmp_copro; // RULE13
      ety_mm <= link_ok && cmp_ety; // RULE15
    end
  end

  // ----------------------------------------------------------------
  // state word assembly
  // ----------------------------------------------------------------
  wire [W-1:0] state_word = { // RULE6 RULE20
    COPRO_OK, // RULE17
    1'b0,
    role == RS_STANDBY, // RULE16
    2'h0,
    ety_mm,
    ety_old,
    copro_mm,
    cpu_mm,
    link_bad,
    unit_b,
    logic_mm,
    peer_code,
    role_code(role) // RULE7
  };

  // ----------------------------------------------------------------
  // memory words
  // ----------------------------------------------------------------
  wire peer_mem_ok = LINK_RX.mem_valid && role == RS_STANDBY && peer_primary;
  wire peer_mem_xfer = LINK_RX.mem_idx >= NONXFER_WORDS; // RULE19
  wire mem_from_peer = peer_mem_ok && peer_mem_xfer;

  always_ff @(posedge MCLK) begin
    if (wr_mem) begin
      mem[mem_idx] <= WDATA;
    end
    if (mem_from_peer) begin
      mem[LINK_RX.mem_idx] <= LINK_RX.mem_data; // RULE19
    end
  end

  // ----------------------------------------------------------------
  // primary memory sweep
  // ----------------------------------------------------------------
  wire sweep_start = SCAN_TICK && role == RS_PRIMARY;
  wire sweep_end = sweep_idx == MEM_LAST;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sweep_on <= 1'b0;
      sweep_idx <= 7'h00;
    end else if (sweep_start) begin
      sweep_on <= 1'b1;
      sweep_idx <= NONXFER_WORDS; // RULE19
    end else if (sweep_on) begin
      sweep_on <= !sweep_end;
      sweep_idx <= sweep_end ? sweep_idx : sweep_idx + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // outgoing link frame
  // ----------------------------------------------------------------
  logic [BACK_WORDS*W-1:0] back_flat;

  always_comb begin
    back_flat = '0;
    for (int i = 0; i < BACK_WORDS; i++) begin
      back_flat[i*W +: W] = back[i];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      LINK_TX <= '0;
    end else begin
      LINK_TX.alive <= COPRO_OK;
      LINK_TX.role <= role_code(role);
      LINK_TX.cmd <= cmd; // RULE3
      LINK_TX.back <= back_flat; // RULE18
      LINK_TX.logic_sig <= LOCAL_LOGIC_SIG;
      LINK_TX.cpu_fw <= LOCAL_CPU_FW;
      LINK_TX.copro_fw <= LOCAL_COPRO_FW;
      LINK_TX.ety_fw <= LOCAL_ETY_FW;
      LINK_TX.mac <= LOCAL_MAC;
      LINK_TX.mem_valid <= sweep_on;
      LINK_TX.mem_idx <= sweep_idx;
      LINK_TX.mem_data <= mem[sweep_idx];
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  wire [W-1:0] rd_mux =
    sel_cmd ? cmd :
    sel_state ? state_word :
    sel_back ? back[back_idx] :
    sel_mem ? mem[mem_idx] :
    16'h0000;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

// File: testbench/rscr_chk.sv
// checker for the redundancy command and state register bank
// assumes one clock MCLK and an active low asynchronous RSTN
`timescale 1ns/1ps
`default_nettype none

module rscr_chk
  import rscr_pkg::*;
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic RD,
  input wire logic [W-1:0] RDATA,
  input wire logic SCAN_TICK,
  input wire logic ETY_MIN_OK,
  input wire logic COPRO_OK,
  input wire rscr_link_t LINK_TX,
  input wire logic RUN_FIRST_SECTION,
  input wire logic RUN_ALL_SECTIONS,
  input wire logic IO_ENABLE,
  input wire logic ADDR_PLUS_ONE
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  wire logic pri = LINK_TX.role == ROLE_PRIMARY;
  wire logic sby = LINK_TX.role == ROLE_STANDBY;

  AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == '0)
    else $error("read data not zero outside read slot");
  AST_RD_CMD: assert property (RD && ADDR == ADDR_CMD |=>
    (RDATA & ~CMD_USED) == '0)
    else $error("unused command bits read nonzero");
  AST_ROLE_PRI: assert property (RUN_ALL_SECTIONS == pri)
    else $error("full program run not tied to primary");
  AST_OFF_IDLE: assert property (LINK_TX.role == ROLE_OFFLINE |->
    !RUN_FIRST_SECTION && !IO_ENABLE)
    else $error("offline unit runs program or io");
  AST_SBY_FIRST: assert property (sby |-> RUN_FIRST_SECTION &&
    !RUN_ALL_SECTIONS && IO_ENABLE)
    else $error("standby unit runs wrong sections");
  AST_ADDR_PLUS: assert property (ADDR_PLUS_ONE == sby)
    else $error("address offset not tied to standby");
  AST_ETY_OFF: assert property (SCAN_TICK && !ETY_MIN_OK |->
    ##2 LINK_TX.role == ROLE_OFFLINE)
    else $error("old network firmware did not force offline");
  AST_ALIVE: assert property ($past(RSTN) |->
    LINK_TX.alive == $past(COPRO_OK))
    else $error("link alive does not follow coprocessor health");
  AST_MEM_TX: assert property (LINK_TX.mem_valid |->
    LINK_TX.mem_idx >= NONXFER_WORDS)
    else $error("non transferred memory word sent");
endmodule

bind rscr_regs rscr_chk u_chk (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR),
  .RD(RD), .RDATA(RDATA), .SCAN_TICK(SCAN_TICK), .ETY_MIN_OK(ETY_MIN_OK),
  .COPRO_OK(COPRO_OK), .LINK_TX(LINK_TX),
  .RUN_FIRST_SECTION(RUN_FIRST_SECTION), .RUN_ALL_SECTIONS(RUN_ALL_SECTIONS),
  .IO_ENABLE(IO_ENABLE), .ADDR_PLUS_ONE(ADDR_PLUS_ONE));
`default_nettype wire

// File: testbench/rscr_peer.sv
// peer redundant unit, sends its frame over the synchronisation link
// assumes the peer shares MCLK and is steered by the bench
`timescale 1ns/1ps
`default_nettype none

module rscr_peer
  import rscr_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] role,
  input wire logic [W-1:0] cmd,
  input wire logic [W-1:0] fw,
  input wire logic [W-1:0] sig,
  input wire logic [47:0] mac,
  input wire logic [BACK_WORDS*W-1:0] back,
  input wire logic mem_go,
  input wire logic [MIDX_W-1:0] mem_idx,
  input wire logic [W-1:0] mem_data,
  output var rscr_link_t frame
);
  // ----------------------------------------------------------------
  // frame register, garbage where a field carries no meaning
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      frame <= '0;
    end else begin
      frame.alive <= 1'b1;
      frame.role <= role;
      frame.cmd <= role == ROLE_PRIMARY ? cmd : ~frame.cmd;
      frame.back <= role == ROLE_STANDBY ? back : ~frame.back;
      frame.logic_sig <= sig;
      frame.cpu_fw <= fw;
      frame.copro_fw <= fw;
      frame.ety_fw <= fw;
      frame.mac <= mac;
      frame.mem_valid <= mem_go;
      frame.mem_idx <= mem_idx;
      frame.mem_data <= mem_go ? mem_data : ~frame.mem_data;
    end
  end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the redundancy register bank
// assumes the peer model on the link and the checker bound in
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import rscr_pkg::*;
  logic MCLK, RSTN, WR, RD, SCAN_TICK, ETY_MIN_OK, COPRO_OK;
  logic [ADDR_W-1:0] ADDR;
  logic [W-1:0] WDATA, l_fw, p_cmd, p_fw, p_sig, p_data;
  logic [W-1:0] RDATA;
  logic [1:0] p_role;
  logic [47:0] p_mac;
  logic [BACK_WORDS*W-1:0] p_back;
  logic p_go;
  logic [MIDX_W-1:0] p_idx;
  logic rfs, ras, ioe, apo;
  rscr_link_t rx, tx;
  int n_errors, check_count, cyc;

  rscr_regs dut (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SCAN_TICK(SCAN_TICK),
    .LOCAL_MAC(48'h1), .LOCAL_CPU_FW(l_fw), .LOCAL_COPRO_FW(l_fw),
    .LOCAL_ETY_FW(l_fw), .LOCAL_LOGIC_SIG(16'h00a5),
    .ETY_MIN_OK(ETY_MIN_OK), .COPRO_OK(COPRO_OK), .LINK_RX(rx),
    .LINK_TX(tx), .RUN_FIRST_SECTION(rfs), .RUN_ALL_SECTIONS(ras),
    .IO_ENABLE(ioe), .ADDR_PLUS_ONE(apo));
  rscr_peer peer (.mclk(MCLK), .rstn(RSTN), .role(p_role), .cmd(p_cmd),
    .fw(p_fw), .sig(p_sig), .mac(p_mac), .back(p_back), .mem_go(p_go),
    .mem_idx(p_idx), .mem_data(p_data), .frame(rx));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [W-1:0] g, input logic [W-1:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [W-1:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [W-1:0] e,
    input logic [W-1:0] m);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 chk(RDATA & m, e);
  endtask
  task automatic tick;
    @(posedge MCLK);
    SCAN_TICK <= 1'b1;
    @(posedge MCLK);
    SCAN_TICK <= 1'b0;
    repeat (4) @(posedge MCLK);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(ADDR_CMD, 16'h0000, 16'hffff);
    rd(ADDR_STATE, 16'h8001, 16'hffff);
    wr(ADDR_STATE, 16'hffff);
    rd(ADDR_STATE, 16'h8001, 16'hffff);
    rd(10'h008, 16'h0000, 16'hffff);
  endtask
  task automatic t_primary;
    wr(ADDR_CMD, 16'hffff);
    rd(ADDR_CMD, 16'h0016, 16'hffff);
    wr(ADDR_CMD, 16'h0002);
    tick;
    rd(ADDR_STATE, 16'h8006, 16'hffff);
    chk({15'h0, ras}, 16'h0001);
    chk({14'h0, rfs, apo}, 16'h0002);
    wr(ADDR_CMD, 16'h0004);
    tick;
    rd(ADDR_STATE, 16'h8005, 16'hffff);
    wr(ADDR_CMD, 16'h0002);
    tick;
    #1 chk(tx.cmd, 16'h0002);
  endtask
  task automatic t_back;
    p_role <= ROLE_STANDBY;
    p_fw <= 16'h0200;
    p_back <= {16'h4444, 16'h3333, 16'h2222, 16'h1111};
    tick;
    rd(ADDR_STATE, 16'h800e, 16'hffff);
    for (int i = 0; i < BACK_WORDS; i++) begin
      rd(10'(16 + 4 * i), 16'(16'h1111 * (i + 1)), 16'hffff);
    end
    p_fw <= l_fw;
  endtask
  task automatic t_standby;
    p_role <= ROLE_PRIMARY;
    p_mac <= 48'h0;
    p_cmd <= 16'h0014;
    wr(ADDR_CMD, 16'h0006);
    repeat (3) tick;
    rd(ADDR_STATE, 16'ha02b, 16'hffff);
    chk({14'h0, rfs, ras}, 16'h0002);
    chk({14'h0, ioe, apo}, 16'h0003);
    wr(ADDR_CMD, 16'h0006);
    tick;
    rd(ADDR_CMD, 16'h0014, 16'hffff);
    wr(10'h010, 16'h00c3);
    @(posedge MCLK);
    #1 chk(tx.back[15:0], 16'h00c3);
  endtask
  task automatic t_mem;
    wr(10'h214, 16'h1234);
    @(posedge MCLK);
    p_go <= 1'b1;
    p_idx <= 7'h05;
    p_data <= 16'hbeef;
    @(posedge MCLK);
    p_idx <= 7'h64;
    p_data <= 16'h5a5a;
    @(posedge MCLK);
    p_go <= 1'b0;
    rd(10'h214, 16'h1234, 16'hffff);
    rd(10'h390, 16'h5a5a, 16'hffff);
  endtask
  task automatic t_fw;
    p_fw <= 16'h0200;
    tick;
    rd(ADDR_STATE, 16'ha5ab, 16'hffff);
    p_cmd <= 16'h0004;
    repeat (2) tick;
    rd(ADDR_STATE, 16'h85a9, 16'hffff);
    chk({14'h0, rfs, ioe}, 16'h0000);
  endtask
  task automatic t_faults;
    p_sig <= 16'h005a;
    tick;
    rd(ADDR_STATE, 16'h0010, 16'h0010);
    ETY_MIN_OK <= 1'b0;
    COPRO_OK <= 1'b0;
    tick;
    rd(ADDR_STATE, 16'h0240, 16'h824c);
  endtask
  task automatic t_failover;
    ETY_MIN_OK <= 1'b1;
    COPRO_OK <= 1'b1;
    p_sig <= 16'h00a5;
    p_fw <= l_fw;
    repeat (2) tick;
    rd(ADDR_STATE, 16'ha02b, 16'hffff);
    p_role <= ROLE_OFFLINE;
    tick;
    rd(ADDR_STATE, 16'h8026, 16'hffff);
    rd(ADDR_CMD, 16'h0004, 16'hffff);
    chk({15'h0, ras}, 16'h0001);
  endtask

  // ----------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      end_sim;
    end
  end
  initial begin
    {RSTN, WR, RD, SCAN_TICK, p_go} = '0;
    {ETY_MIN_OK, COPRO_OK} = 2'h3;
    {ADDR, WDATA, p_cmd, p_back, p_idx, p_data} = '0;
    l_fw = 16'h0100;
    p_fw = 16'h0100;
    p_sig = 16'h00a5;
    p_mac = 48'h2;
    p_role = ROLE_OFFLINE;
    repeat (6) @(posedge MCLK);
    RSTN <= 1'b1;
    t_reset;
    t_primary;
    t_back;
    t_standby;
    t_mem;
    t_fw;
    t_faults;
    t_failover;
    end_sim;
  end
endmodule
`default_nettype wire
